// >>> common/dcp_pkg.sv
// types shared by the pwm / delatch block
// assumes dcp_regs.svh constants are used by the design files
package dcp_pkg;
  // per channel configuration handed to the modulator
  typedef struct packed {
    logic on_bit;
    logic [7:0] duty;
    logic [2:0] delay;
    logic clock_int;
    logic prescale_double;
    logic mod_en;
  } dcp_chan_cfg_t;

  typedef struct packed {
    logic oc;
    logic sc;
    logic ot;
  } dcp_latchable_t;

  typedef enum logic [1:0] {
    DCP_IDLE = 2'b00,
    DCP_DELAY = 2'b01,
    DCP_RUN = 2'b11
  } dcp_mod_st_t;

  typedef enum logic [1:0] {
    DCP_CAL_OFF = 2'b00,
    DCP_CAL_ARMED = 2'b01,
    DCP_CAL_MEAS = 2'b11
  } dcp_cal_st_t;
endpackage : dcp_pkg

// >>> common/dcp_regs.svh
// timing counts and widths for the dual pwm / delatch block
// assumes inclusion by bare name; definitions only
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH
`define DCP_CLK_MHZ 100
`define DCP_DUTY_W 8
`define DCP_DUTY_FULL 8'hff
`define DCP_DLY_W 3
`define DCP_DLY_STEP 32
`define DCP_DLY_CNT_W 8
`define DCP_CSB_MIN_NS 1000
`define DCP_CSB_MAX_NS 40000
`define DCP_CSB_MIN_CYC ((`DCP_CSB_MIN_NS * `DCP_CLK_MHZ + 999) / 1000)
`define DCP_CSB_MAX_CYC ((`DCP_CSB_MAX_NS * `DCP_CLK_MHZ) / 1000)
`define DCP_CAL_W 16
`define DCP_INT_DIV_DEF 16'h0064
`define DCP_EXT_MIN_CYC 16'h0004
`define DCP_EXT_MAX_CYC 16'h4000
`define DCP_RETRY_W 4
`endif

// >>> dv/dcp_host_model.sv
// host side model: external pwm clock and the chip-select calibration pulse
// assumes clk is the block clock; outputs change just after its rising edge
`timescale 1ns/1ps
module dcp_host_model (
  input wire logic clk,
  input wire logic ext_run,
  input wire logic cal_go,
  input wire logic [15:0] cal_len,
  output logic ext_clock,
  output logic cs_n
);
  // ****************
  // host stimulus
  // ****************
  int ph;
  int left;
  initial begin
    ext_clock = 1'b0;
    cs_n = 1'b1;
    ph = 0;
    left = 0;
  end
  // clock period 8 cycles, stands still low when stopped so a gap is real
  always @(posedge clk) begin
    ph <= (ph + 1) % 4;
    if (!ext_run) begin
      ext_clock <= 1'b0;
    end else if (ph == 3) begin
      ext_clock <= ~ext_clock;
    end
  end
  // chip select held low for cal_len cycles, then released high
  always @(posedge clk) begin
    if (cal_go) begin
      cs_n <= 1'b0;
      left <= cal_len;
    end else if (left > 1) begin
      left <= left - 1;
    end else begin
      cs_n <= 1'b1;
      left <= 0;
    end
  end
endmodule : dcp_host_model

// >>> dv/dcp_pwm_delatch_properties.sv
// checker for dcp_pwm_delatch: delatch timing, mirroring and fault status
// assumes one clock domain with srst synchronous, active high
`timescale 1ns/1ps
module dcp_pwm_delatch_properties (
  input wire logic clk,
  input wire logic srst,
  input wire logic power_on_evt,
  input wire logic parallel,
  input wire logic fail_safe,
  input wire logic fault_mode,
  input wire logic [2:0] diag_cfg1,
  input wire logic [3:0] retry_cnt0,
  input wire logic [3:0] retry_cnt1,
  input wire logic [1:0] retry_reset,
  input wire dcp_pkg::dcp_latchable_t flt0,
  input wire dcp_pkg::dcp_latchable_t flt1,
  input wire logic [1:0] retries_exhausted,
  input wire logic [1:0] fault_read,
  input wire logic fault_status_out_n,
  input wire logic clock_fail_flag,
  input wire dcp_pkg::dcp_latchable_t fault_report0,
  input wire dcp_pkg::dcp_latchable_t fault_report1,
  input wire logic [2:0] diag_cfg1_eff,
  input wire logic [3:0] retry_cnt1_eff,
  input wire logic [1:0] latched,
  input wire logic reg_reset_pulse
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // a latch request in the same cycle would win over a delatch, so exclude it
  wire logic nox = (retries_exhausted == 2'h0);
  sequence s_fs_pulse;
    reg_reset_pulse && latched == 2'h0 ##1 !reg_reset_pulse;
  endsequence
  property p_diag_pass; diag_cfg1_eff == diag_cfg1; endproperty
  a_diag_pass: assert property (p_diag_pass)
    else $error("channel 1 diagnostic bits altered");
  property p_retry_mirror; retry_cnt1_eff == (parallel ? retry_cnt0 : retry_cnt1); endproperty
  a_retry_mirror: assert property (p_retry_mirror)
    else $error("channel 1 retry count not mirrored correctly");
  property p_status_low; latched != 2'h0 |-> !fault_status_out_n; endproperty
  a_status_low: assert property (p_status_low)
    else $error("fault status released while a channel is latched");
  property p_por_clear;
    power_on_evt && nox && flt0 == '0 && flt1 == '0 |=> latched == 2'h0 &&
      fault_report0 == '0 && fault_report1 == '0 && !clock_fail_flag;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("power-on did not clear latches and faults");
  property p_read_latched;
    fault_read[0] && latched[0] && flt0 == '0 && !fail_safe && !power_on_evt |=>
      !latched[0] || fault_report0 == $past(fault_report0);
  endproperty
  a_read_latched: assert property (p_read_latched)
    else $error("latched fault bit cleared by a read");
  property p_fs_entry; $rose(fail_safe) && fault_mode && nox |=> s_fs_pulse; endproperty
  a_fs_entry: assert property (p_fs_entry)
    else $error("fail-safe entry from fault mode did not delatch and reset");
  property p_retry_delatch; retry_reset[0] && nox && !fail_safe |=> !latched[0]; endproperty
  a_retry_delatch: assert property (p_retry_delatch)
    else $error("retry counter reset did not delatch channel 0");
  property p_par_delatch;
    parallel && retry_reset[0] && nox && !fail_safe |=> latched == 2'h0;
  endproperty
  a_par_delatch: assert property (p_par_delatch)
    else $error("parallel delatch of channel 0 left channel 1 latched");
endmodule : dcp_pwm_delatch_properties

bind dcp_pwm_delatch dcp_pwm_delatch_properties u_props (
  .clk, .srst, .power_on_evt, .parallel, .fail_safe, .fault_mode, .diag_cfg1,
  .retry_cnt0, .retry_cnt1, .retry_reset, .flt0, .flt1, .retries_exhausted, .fault_read,
  .fault_status_out_n, .clock_fail_flag, .fault_report0, .fault_report1, .diag_cfg1_eff,
  .retry_cnt1_eff, .latched, .reg_reset_pulse
);

// >>> dv/tb.sv
// self-checking bench for dcp_pwm_delatch with the host model beside it
// assumes the checker binds itself; external clock period is 8 block clocks
`timescale 1ns/1ps
module tb;
  // ****************
  // bench
  // ****************
  typedef struct packed {
    logic on; logic ci; logic [7:0] duty; logic pd; logic [15:0] want;
  } dcp_row_t;
  logic clk, srst, power_on_evt, parallel, fail_safe, fault_mode, diag_read, cal_cmd;
  logic ext_clock, cs_n, fault_status_out_n, clock_fail_flag, reg_reset_pulse, ext_run, cal_go;
  logic [1:0] direct_in, direct_dis, retry_reset, retry_running, retries_exhausted, fault_read;
  logic [1:0] switch_output, latched;
  logic [2:0] diag_cfg0, diag_cfg1, diag_cfg1_eff;
  logic [3:0] retry_cnt0, retry_cnt1, retry_cnt1_eff;
  logic [15:0] int_clk_div, cal_len, c0, c1;
  dcp_pkg::dcp_chan_cfg_t cfg0, cfg1;
  dcp_pkg::dcp_latchable_t flt0, flt1, fault_report0, fault_report1;
  int errors, comparisons, n, ticks;
  logic last;
  // on-time in block clocks over one full switching period
  dcp_row_t rows [0:5] = '{'{1'b1, 1'b0, 8'h00, 1'b0, 16'h0008},
    '{1'b1, 1'b0, 8'h7f, 1'b0, 16'h0400}, '{1'b1, 1'b0, 8'hff, 1'b0, 16'h0800},
    '{1'b1, 1'b0, 8'h3f, 1'b1, 16'h0400}, '{1'b0, 1'b0, 8'h80, 1'b0, 16'h0000},
    '{1'b1, 1'b1, 8'h0f, 1'b1, 16'h00b0}};
  dcp_pwm_delatch DUT (.*);
  dcp_host_model u_host (.clk, .ext_run, .cal_go, .cal_len, .ext_clock, .cs_n);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    comparisons++;
    if (seen !== want) begin
      errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude
  task automatic give_up(input string what);
    errors++;
    $display("Error %s expected done seen timeout", what);
    conclude();
  endtask : give_up
  task automatic calib(input logic [15:0] len, input logic [15:0] want);
    cal_len = len;
    cal_cmd = 1'b1;
    @(negedge clk);
    {cal_cmd, cal_go} = 2'b01;
    @(negedge clk);
    cal_go = 1'b0;
    repeat (len + 4) @(negedge clk);
    for (n = 0; n < 20 && int_clk_div !== want; n++) @(negedge clk);
    check("internal divider", int_clk_div, want);
  endtask : calib
  task automatic latch(input logic [1:0] ch);
    {flt0.oc, flt1.oc, retries_exhausted} = {ch[0], ch[1], ch};
    @(negedge clk);
    {flt0, flt1, retries_exhausted} = '0;
    repeat (2) @(negedge clk);
  endtask : latch
  // one pulse on fault_read (sel 0) or retry_reset (sel 1), low at the next falling edge
  // the bench signal is driven directly so the pulse is seen while the task runs
  task automatic pulse(input logic sel, input logic [1:0] val);
    if (sel) begin
      retry_reset = val;
    end else begin
      fault_read = val;
    end
    @(negedge clk);
    if (sel) begin
      retry_reset = 2'h0;
    end else begin
      fault_read = 2'h0;
    end
    repeat (2) @(negedge clk);
  endtask : pulse
  initial begin
    {errors, comparisons} = '0;
    srst = 1'b1;
    {power_on_evt, parallel, fail_safe, fault_mode, diag_read, cal_cmd, ext_run, cal_go} = '0;
    {direct_in, direct_dis, retry_reset, retry_running, retries_exhausted, fault_read} = '0;
    {cfg0, cfg1, flt0, flt1, diag_cfg0} = '0;
    {diag_cfg1, retry_cnt0, retry_cnt1, cal_len} = {3'h5, 4'ha, 4'h3, 16'h0000};
    repeat (20) @(negedge clk);
    srst = 1'b0;
    @(negedge clk);
    check("latched", latched, 2'h0);
    check("status", fault_status_out_n, 1'b1);
    check("switch off", switch_output, 2'h0);
    check("retry ch1", retry_cnt1_eff, 4'h3);
    calib(16'h0032, 16'h0064);
    calib(16'h1004, 16'h0064);
    calib(16'h0a28, 16'h000a);
    $display("reset and calibration done");
    ext_run = 1'b1;
    for (int i = 0; i < 6; i++) begin
      cfg0 = '{rows[i].on, rows[i].duty, 3'h0, rows[i].ci, rows[i].pd, 1'b0};
      cfg1 = cfg0;
      @(negedge clk);
      {cfg0.mod_en, cfg1.mod_en} = 2'b11; // both in one write
      repeat (16) @(negedge clk);
      {c0, c1} = '0;
      repeat (rows[i].ci ? 2816 : (rows[i].pd ? 4096 : 2048)) begin
        @(negedge clk);
        c0 = c0 + switch_output[0];
        c1 = c1 + switch_output[1];
      end
      check("on time ch0", c0, rows[i].want);
      check("on time ch1", c1, rows[i].want);
    end
    $display("duty rows done");
    cfg0 = '{1'b1, 8'h00, 3'h7, 1'b0, 1'b0, 1'b0};
    cfg1 = '0;
    @(negedge clk);
    cfg0.mod_en = 1'b1;
    for (n = 0; switch_output[0] !== 1'b0; n++) if (n > 50) give_up("delay start");
      else @(negedge clk);
    for (ticks = 0; switch_output[0] !== 1'b1; ) begin
      last = ext_clock;
      @(negedge clk);
      ticks += (ext_clock && !last);
      if (ticks > 400) give_up("delay end");
    end
    check("delay steps", (ticks + 16) / 32, 16'h0007);
    ext_run = 1'b0;
    for (n = 0; clock_fail_flag !== 1'b1; n++) if (n > 17000) give_up("clock fail");
      else @(negedge clk);
    check("fail status", fault_status_out_n, 1'b0);
    check("follows on bit", switch_output[0], 1'b1);
    diag_read = 1'b1;
    @(negedge clk);
    check("flag kept", clock_fail_flag, 1'b1);
    ext_run = 1'b1;
    repeat (40) @(negedge clk);
    diag_read = 1'b0;
    @(negedge clk);
    check("flag cleared", clock_fail_flag, 1'b0);
    cfg0.mod_en = 1'b0;
    $display("delay and clock monitor done");
    {direct_in, cfg0.on_bit} = 3'b101;
    latch(2'h3);
    check("both latched", latched, 2'h3);
    check("latched off", switch_output, 2'h0);
    pulse(1'b0, 2'h3);
    check("report kept", fault_report0, 3'h4);
    cfg0.on_bit = 1'b0;
    @(negedge clk);
    cfg0.on_bit = 1'b1; // spi toggle, no minimum off time
    repeat (2) @(negedge clk);
    check("ch0 delatched", latched, 2'h2);
    check("status held", fault_status_out_n, 1'b0);
    direct_in[1] = 1'b0;
    repeat (4) @(negedge clk);
    direct_in[1] = 1'b1; // direct input low then high
    repeat (2) @(negedge clk);
    check("ch1 delatched", latched, 2'h0);
    check("status free", fault_status_out_n, 1'b1);
    parallel = 1'b1;
    flt1.sc = 1'b1;
    repeat (2) @(negedge clk);
    check("sc both", {fault_report0, fault_report1}, 6'h12);
    check("par off", switch_output, 2'h0);
    check("par retry", retry_cnt1_eff, 4'ha);
    check("par diag", diag_cfg1_eff, 3'h5);
    flt1.sc = 1'b0;
    latch(2'h1);
    check("par latched", latched, 2'h3);
    pulse(1'b1, 2'h1);
    check("par delatch", latched, 2'h0);
    parallel = 1'b0;
    latch(2'h1);
    fault_mode = 1'b1;
    fail_safe = 1'b1;
    @(negedge clk);
    check("reg reset", reg_reset_pulse, 1'b1);
    check("fs delatch", latched, 2'h0);
    latch(2'h1);
    repeat (4) @(negedge clk);
    check("fs no delatch", latched, 2'h1);
    {fail_safe, fault_mode, power_on_evt} = 3'b001;
    @(negedge clk);
    power_on_evt = 1'b0;
    @(negedge clk);
    check("por latched", latched, 2'h0);
    check("por reports", {fault_report0, fault_report1}, 6'h00);
    $display("delatch, parallel and power-on done");
    conclude();
  end
endmodule : tb

// >>> src/dcp_modulator.sv
// one channel modulator: switch-on delay, 8-bit period counter, duty compare
// assumes tick pulses mark one selected clock period, synchronous to clk
`timescale 1ns/1ps
`include "dcp_regs.svh"
module dcp_modulator (
  input wire logic clk,
  input wire logic srst,
  input wire dcp_pkg::dcp_chan_cfg_t cfg,
  input wire logic tick,
  output logic pwm_out
);
  typedef struct packed {
    dcp_pkg::dcp_mod_st_t st;
    logic [`DCP_DLY_CNT_W-1:0] dly;
    logic [`DCP_DUTY_W-1:0] cnt;
    logic out;
  } dcp_mod_state_t;

  dcp_mod_state_t cur;
  dcp_mod_state_t next_cur;

  // ************************************************************
  // modulator sequencing
  // ************************************************************
  // delay counts 32*value ticks before the first period starts
  always_comb begin
    next_cur = cur;
    if (!cfg.mod_en) begin
      next_cur.st = dcp_pkg::DCP_IDLE;
      next_cur.cnt = '0;
      next_cur.dly = '0;
    end else begin
      unique case (cur.st)
        dcp_pkg::DCP_IDLE: begin
          next_cur.dly = {cfg.delay, 5'h00};
          next_cur.st = (cfg.delay == 3'h0) ? dcp_pkg::DCP_RUN : dcp_pkg::DCP_DELAY;
        end
        dcp_pkg::DCP_DELAY: begin
          if (tick) begin
            next_cur.dly = cur.dly - 8'h01;
            if (cur.dly == 8'h01) begin
              next_cur.st = dcp_pkg::DCP_RUN;
            end
          end
        end
        dcp_pkg::DCP_RUN: begin
          if (tick) begin
            next_cur.cnt = cur.cnt + 8'h01;
          end
        end
        default: next_cur.st = dcp_pkg::DCP_IDLE;
      endcase
    end
    // off when on bit low; full on at ff or with mod_en low; else on in run while counter <= duty
    if (!cfg.on_bit) begin
      next_cur.out = 1'b0;
    end else if (!cfg.mod_en || cfg.duty == `DCP_DUTY_FULL) begin
      next_cur.out = 1'b1;
    end else begin
      next_cur.out = (next_cur.st == dcp_pkg::DCP_RUN) &&
                     (next_cur.cnt <= cfg.duty);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign pwm_out = cur.out;
endmodule : dcp_modulator

// >>> src/dcp_pwm_delatch.sv
// dual channel pwm generation, clock selection and monitoring, calibration,
// fault delatching and parallel-mode mirroring.
// assumes all inputs synchronous to clk; fault detectors and spi decode live
// outside and present decoded bits and one-cycle event pulses here.
`timescale 1ns/1ps
`include "dcp_regs.svh"
module dcp_pwm_delatch (
  input wire logic clk,
  input wire logic srst,
  input wire logic power_on_evt,
  input wire logic parallel,
  input wire logic fail_safe,
  input wire logic fault_mode,
  input wire logic [1:0] direct_in,
  input wire logic [1:0] direct_dis,
  input wire dcp_pkg::dcp_chan_cfg_t cfg0,
  input wire dcp_pkg::dcp_chan_cfg_t cfg1,
  input wire logic [2:0] diag_cfg0,
  input wire logic [2:0] diag_cfg1,
  input wire logic [3:0] retry_cnt0,
  input wire logic [3:0] retry_cnt1,
  input wire logic [1:0] retry_reset,
  input wire logic [1:0] retry_running,
  input wire dcp_pkg::dcp_latchable_t flt0,
  input wire dcp_pkg::dcp_latchable_t flt1,
  input wire logic [1:0] retries_exhausted,
  input wire logic [1:0] fault_read,
  input wire logic diag_read,
  input wire logic ext_clock,
  input wire logic cal_cmd,
  input wire logic cs_n,
  output logic [1:0] switch_output,
  output logic fault_status_out_n,
  output logic clock_fail_flag,
  output dcp_pkg::dcp_latchable_t fault_report0,
  output dcp_pkg::dcp_latchable_t fault_report1,
  output logic [2:0] diag_cfg1_eff,
  output logic [3:0] retry_cnt1_eff,
  output logic [1:0] latched,
  output logic reg_reset_pulse,
  output logic [15:0] int_clk_div
);
  typedef struct packed {
    logic [1:0] fc_q;
    logic [1:0] fc_seen_low;
    logic [1:0] latched;
    logic [1:0] force_on;
    dcp_pkg::dcp_latchable_t rep0;
    dcp_pkg::dcp_latchable_t rep1;
    logic fs_q;
    logic ck_q;
    logic [15:0] ck_cnt;
    logic ck_fail;
    logic [15:0] div;
    logic [1:0][15:0] int_cnt;
    logic [1:0] pre;
    dcp_pkg::dcp_cal_st_t cal_st;
    logic [15:0] cal_cnt;
    logic cs_q;
    logic rst_pulse;
  } dcp_top_state_t;

  dcp_top_state_t cur;
  dcp_top_state_t next_cur;
  logic [1:0] fc;
  logic [1:0] tick;
  logic [1:0] pwm;
  logic [1:0] delatch;
  logic ext_rise;
  logic ext_ok;
  dcp_pkg::dcp_chan_cfg_t eff0;
  dcp_pkg::dcp_chan_cfg_t eff1;
  dcp_pkg::dcp_chan_cfg_t mod_cfg [2];
  dcp_pkg::dcp_latchable_t flt_any;

  // ************************************************************
  // parallel mirroring and fault control
  // ************************************************************
  // in parallel mode bank 1 is bank 0; diagnostic bits stay per channel
  always_comb begin
    eff0 = cfg0;
    eff1 = parallel ? cfg0 : cfg1;
    diag_cfg1_eff = diag_cfg1;
    retry_cnt1_eff = parallel ? retry_cnt0 : retry_cnt1;
    flt_any = flt0 | flt1;
  end

  // direct input counts unless disabled, or spi on bit
  assign fc[0] = (direct_in[0] && !direct_dis[0]) || eff0.on_bit;
  assign fc[1] = (direct_in[1] && !direct_dis[1]) || eff1.on_bit;
  assign ext_rise = ext_clock && !cur.ck_q;
  assign ext_ok = !cur.ck_fail;

  // ************************************************************
  // clock ticks per channel
  // ************************************************************
  // external edges pass through an optional divide-by-two prescaler
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_chan
      dcp_pkg::dcp_chan_cfg_t c;
      assign c = (gi == 0) ? eff0 : eff1;
      always_comb begin
        if (c.clock_int) begin
          tick[gi] = (cur.int_cnt[gi] == 16'h0000);
        end else begin
          tick[gi] = ext_ok && ext_rise && (!c.prescale_double || cur.pre[gi]);
        end
        mod_cfg[gi] = c;
        // a failed external clock leaves the channel on its on bit
        if (!c.clock_int && cur.ck_fail) begin
          mod_cfg[gi].mod_en = 1'b0;
        end
      end
      // one shared edge source keeps both external modulators aligned
      dcp_modulator u_mod (
        .clk(clk),
        .srst(srst),
        .cfg(mod_cfg[gi]),
        .tick(tick[gi]),
        .pwm_out(pwm[gi])
      );
    end
  endgenerate

  // ************************************************************
  // delatch, latching, reports and monitoring
  // ************************************************************
  always_comb begin
    next_cur = cur;
    next_cur.fc_q = fc;
    next_cur.ck_q = ext_clock;
    next_cur.cs_q = cs_n;
    next_cur.fs_q = fail_safe;
    next_cur.rst_pulse = 1'b0;
    // 1-0-1: remember a low, fire on the next rising edge (turn-on)
    for (int i = 0; i < 2; i++) begin
      if (!fc[i]) begin
        next_cur.fc_seen_low[i] = 1'b1;
      end
      delatch[i] = (fc[i] && !cur.fc_q[i] && cur.fc_seen_low[i]) || retry_reset[i];
      if (delatch[i]) begin
        next_cur.fc_seen_low[i] = 1'b0;
      end
    end
    if (parallel) begin
      delatch[1] = delatch[0];
    end
    for (int i = 0; i < 2; i++) begin
      next_cur.force_on[i] = 1'b0;
      if (delatch[i]) begin
        next_cur.latched[i] = 1'b0;
        next_cur.force_on[i] = retry_running[i] && !cur.latched[i];
      end
      // a latch event in the same cycle as a delatch wins
      if (retries_exhausted[i] || (parallel && retries_exhausted[0])) begin
        next_cur.latched[i] = 1'b1;
      end
    end
    // report bits: set wins over read clear; latched bits survive reads
    if (fault_read[0] && !cur.latched[0]) begin
      next_cur.rep0 = '0;
    end
    if (fault_read[1] && !cur.latched[1]) begin
      next_cur.rep1 = '0;
    end
    if (delatch[0]) begin
      next_cur.rep0 = '0;
    end
    if (delatch[1]) begin
      next_cur.rep1 = '0;
    end
    next_cur.rep0 = next_cur.rep0 | (parallel ? flt_any : flt0);
    next_cur.rep1 = next_cur.rep1 | (parallel ? flt_any : flt1);
    // entering fail-safe from fault mode delatches and resets registers
    if (fail_safe && !cur.fs_q && fault_mode) begin
      next_cur.latched = 2'b00;
      next_cur.rst_pulse = 1'b1;
    end
    // in fail-safe only explicit delatch (handled above) or power-on (below) clears latches
    // external clock monitor: period between edges in clk cycles
    if (ext_rise || cur.ck_cnt != 16'hffff) begin
      next_cur.ck_cnt = ext_rise ? 16'h0000 : cur.ck_cnt + 16'h0001;
    end
    for (int i = 0; i < 2; i++) begin
      if (ext_rise) begin
        next_cur.pre[i] = !cur.pre[i];
      end
      next_cur.int_cnt[i] = (cur.int_cnt[i] == 16'h0000) ? cur.div : cur.int_cnt[i] - 16'h0001;
    end
    if ((!eff0.clock_int && eff0.mod_en) || (!eff1.clock_int && eff1.mod_en)) begin
      if ((ext_rise && cur.ck_cnt < `DCP_EXT_MIN_CYC) || cur.ck_cnt > `DCP_EXT_MAX_CYC) begin
        next_cur.ck_fail = 1'b1;
      end else if (diag_read && ext_rise) begin
        next_cur.ck_fail = 1'b0;
      end
    end else if (diag_read) begin
      next_cur.ck_fail = 1'b0;
    end
    // calibration: armed by command, measures next chip-select low pulse
    unique case (cur.cal_st)
      dcp_pkg::DCP_CAL_OFF: begin
        if (cal_cmd) begin
          next_cur.cal_st = dcp_pkg::DCP_CAL_ARMED;
        end
      end
      dcp_pkg::DCP_CAL_ARMED: begin
        if (!cs_n && cur.cs_q) begin
          next_cur.cal_st = dcp_pkg::DCP_CAL_MEAS;
          next_cur.cal_cnt = 16'h0001;
        end
      end
      dcp_pkg::DCP_CAL_MEAS: begin
        if (cs_n) begin
          next_cur.cal_st = dcp_pkg::DCP_CAL_OFF;
          if (cur.cal_cnt >= 16'(`DCP_CSB_MIN_CYC) && cur.cal_cnt <= 16'(`DCP_CSB_MAX_CYC)) begin
            next_cur.div = {8'h00, cur.cal_cnt[15:8]}; // window / 256 rounded down; a tick then comes every div+1 clocks
          end
        end else if (cur.cal_cnt != 16'hffff) begin
          next_cur.cal_cnt = cur.cal_cnt + 16'h0001;
        end
      end
      default: next_cur.cal_st = dcp_pkg::DCP_CAL_OFF;
    endcase
    // power-on clears latches, reports and clock fail, and restores the default divider
    if (power_on_evt) begin
      next_cur.latched = 2'b00;
      next_cur.rep0 = '0;
      next_cur.rep1 = '0;
      next_cur.ck_fail = 1'b0;
      next_cur.div = `DCP_INT_DIV_DEF;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cur <= '0;
      cur.div <= `DCP_INT_DIV_DEF;
      cur.fc_q <= 2'b11;
    end else begin
      cur <= next_cur;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // both off on any latchable fault in parallel; fault pin low while any latch
  assign switch_output[0] = (pwm[0] || cur.force_on[0]) && !cur.latched[0] &&
                            !(|flt0) && !(parallel && |flt_any);
  assign switch_output[1] = (pwm[1] || cur.force_on[1]) && !cur.latched[1] &&
                            !(|flt1) && !(parallel && |flt_any);
  assign fault_status_out_n = !(|cur.latched) && !cur.ck_fail &&
                              !(|flt_any);
  assign clock_fail_flag = cur.ck_fail;
  assign fault_report0 = cur.rep0;
  assign fault_report1 = cur.rep1;
  assign latched = cur.latched;
  assign reg_reset_pulse = cur.rst_pulse;
  assign int_clk_div = cur.div;
endmodule : dcp_pwm_delatch
